// ==== rtl/gtu_pkg.sv ====
/*
  shared constants and carriers of the general timer unit: register map,
  control field positions, timer indices, pin and output bundles.
  assumes a 32-bit apb register bus with word-aligned registers.
*/
package gtu_pkg;
  // byte offsets
  localparam logic [11:0] OFF_CTL0   = 12'h000; // five control words, one per timer
  localparam logic [11:0] OFF_CNT0   = 12'h014; // five count words, one per timer
  localparam logic [11:0] OFF_CAPTURE_RELOAD_REG = 12'h028;
  localparam logic [11:0] OFF_CAPCFG = 12'h02C;
  localparam logic [11:0] OFF_FLAGS  = 12'h030;
  localparam logic [11:0] OFF_LAST   = 12'h030;

  // timer indices
  localparam int IDX_A    = 0;
  localparam int IDX_CORE = 1;
  localparam int IDX_B    = 2;
  localparam int IDX_MEAS = 3;
  localparam int IDX_BASE = 4;
  localparam int NTIM     = 5;

  // control word fields
  localparam int F_MODE  = 0;  // 2 bits
  localparam int F_RUN   = 2;
  localparam int F_DOWN  = 3;
  localparam int F_EXTDIR = 4;
  localparam int F_PRE   = 5;  // 3 bits, prescale exponent
  localparam int F_ROLE  = 8;  // 2 bits, aux timers only
  localparam int F_LATCLK = 10;
  localparam int F_RISE  = 11; // pin rising edge counts/triggers
  localparam int F_FALL  = 12;
  localparam int F_OE    = 13; // toggle latch drives its pin
  localparam int F_GATE  = 14; // active gate level
  localparam int F_LRISE = 15; // reload on latch rising
  localparam int F_LFALL = 16; // reload on latch falling
  localparam int CTL_W   = 17;
  localparam logic [CTL_W-1:0] CTL_RST = 17'h00000;

  localparam logic [1:0] MODE_TIMER   = 2'h0;
  localparam logic [1:0] MODE_GATED   = 2'h1;
  localparam logic [1:0] MODE_COUNTER = 2'h2;
  localparam logic [1:0] MODE_INCR    = 2'h3;
  localparam logic [1:0] ROLE_NONE    = 2'h0;
  localparam logic [1:0] ROLE_CAPTURE = 2'h1;
  localparam logic [1:0] ROLE_RELOAD  = 2'h2;

  // capture config fields
  localparam int C_RISE = 0;
  localparam int C_FALL = 1;
  localparam int C_PIN  = 2;
  localparam int C_CIN  = 3;
  localparam int C_CDIR = 4;
  localparam int C_CLR  = 5;
  localparam int C_RLD  = 6;
  localparam int CFG_W  = 7;
  localparam logic [CFG_W-1:0] CFG_RST = 7'h00;

  // module one steps every 4 clocks at best, module two every 2
  localparam int SH_ONE = 2;
  localparam int SH_TWO = 1;
  localparam int NFLAG  = 6;

  typedef struct packed {
    logic [4:0] tin;    // timer_input_pin per timer
    logic [4:0] eud;    // direction_input_pin per timer
    logic       capture_input_pin;  // capture_input_pin
  } gtu_pins_t;

  typedef struct packed {
    logic             core_toggle_pin;
    logic             base_toggle_pin;
    logic             base_ovf;  // clock pulse for the compare_array_timers
    logic [NFLAG-1:0] req;       // request flags
  } gtu_out_t;
endpackage

// ==== rtl/gtu_top.sv ====
/*
  general_timer_unit: module_one (aux_timer_a, core_timer, aux_timer_b) and
  module_two (measure_timer, base_timer, capture_reload_reg) behind apb.
  assumes pins are asynchronous to clk_sys and are synchronised here.
*/
// Chosen here: the placing of the registers and register access over APB.
// Function
// (R1) five 16-bit timers, chainable within module
// (R2) module one: timer, gated, counter, incremental
// (R3) timer mode counts prescaled system clock
// (R4) counter mode counts input pin events
// (R5) gated mode counts only at gate level
// (R6) module one resolution four clocks
// (R7) direction from software or direction pin
// (R8) incremental mode decodes quadrature A and B
// (R9) core overflow toggles latch; latch clocks aux
// (R10) aux as capture/reload stops counting
// (R11) aux capture copies core on pin trigger
// (R12) aux reload loads core on pin/latch edge
// (R13) alternating reloads give continuous pwm
// (R14) module two resolution two clocks
// (R15) module two prescaled or external clocking
// (R16) base overflow toggles latch; clocks measure timer
// (R17) base overflow clocks compare array, reloads
// (R18) capture measure timer on capture_input_pin, optional clear
// (R19) capture also from core input/direction pins
// (R20) overflow and capture request flags
`timescale 1ns/1ns
module gtu_top #(
  parameter int TW = 16,
  parameter int PW = 12
) (
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  gtu_pkg::gtu_pins_t      pins,
  output gtu_pkg::gtu_out_t       outs
);
  import gtu_pkg::*;

  if (TW < 2 || TW > 32) begin : g_chk_tw
    $error("gtu_top: TW must be 2..32");
  end
  if (PW < 10) begin : g_chk_pw
    $error("gtu_top: PW must be at least 10");
  end
  if (NTIM != 5 || NFLAG != NTIM + 1) begin : g_chk_map
    $error("gtu_top: package map must hold five timers and six flags");
  end
  if (CTL_W > 32 || CFG_W > 32) begin : g_chk_fields
    $error("gtu_top: control fields must fit one bus word");
  end
  if (int'(OFF_LAST) > 60) begin : g_chk_span
    $error("gtu_top: register map must fit a four-bit word index");
  end
  if (SH_ONE < 1 || SH_TWO < 1) begin : g_chk_sh
    $error("gtu_top: prescaler taps must be at least one bit");
  end

  // two-stage synchroniser, third stage only for edge detection
  gtu_pins_t s1_q, s2_q, s3_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
    end
  end

  // old value for edge detection, kept apart from the synchroniser pair
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s3_q <= '0;
    end else begin
      s3_q <= s2_q;
    end
  end

  function automatic logic rise_of(input logic now, input logic old);
    return now & ~old;
  endfunction

  function automatic logic fall_of(input logic now, input logic old);
    return ~now & old;
  endfunction

  logic [4:0] tin_r, tin_f, eud_e;
  for (genvar e = 0; e < 5; e++) begin : g_edge
    assign tin_r[e] = rise_of(s2_q.tin[e], s3_q.tin[e]);
    assign tin_f[e] = fall_of(s2_q.tin[e], s3_q.tin[e]);
    assign eud_e[e] = rise_of(s2_q.eud[e], s3_q.eud[e]) | fall_of(s2_q.eud[e], s3_q.eud[e]);
  end
  wire       cap_r = rise_of(s2_q.capture_input_pin, s3_q.capture_input_pin);
  wire       cap_f = fall_of(s2_q.capture_input_pin, s3_q.capture_input_pin);

  // registers
  logic [CTL_W-1:0] ctl_q [NTIM];
  logic [TW-1:0]    cnt_q [NTIM];
  logic [TW-1:0]    cnt_d [NTIM];
  logic [TW-1:0]    capture_reload_reg_q, capture_reload_reg_d;
  logic [CFG_W-1:0] cfg_q;
  logic [NFLAG-1:0] flag_q, flag_d;
  logic             core_lat_q, base_lat_q, base_ovf_q;
  logic [PW-1:0]    pre_q;
  logic [31:0]      prdata_q;

  function automatic logic pre_hit(input logic [PW-1:0] c, input logic [2:0] p, input int sh);
    logic [PW-1:0] m;
    m = (PW'(1) << (int'(p) + sh)) - PW'(1);
    return (c & m) == m;
  endfunction

  // per-timer tick, direction and overflow
  logic [NTIM-1:0] tick, down, ovf, pin_ev;
  logic [TW-1:0]   step [NTIM];

  for (genvar i = 0; i < NTIM; i++) begin : g_tim
    localparam int SH = (i < 3) ? SH_ONE : SH_TWO;                       // [R6] [R14]
    wire [1:0] mode   = ctl_q[i][F_MODE+:2];
    wire [1:0] role   = (i == IDX_A || i == IDX_B) ? ctl_q[i][F_ROLE+:2] : ROLE_NONE;
    wire       pre_ev = pre_hit(pre_q, ctl_q[i][F_PRE+:3], SH);          // [R3] [R15]
    // counting the partner's wraps chains two timers into one wide count
    wire       lat_ev = (i == IDX_A || i == IDX_B) ? ovf[IDX_CORE] :
                        (i == IDX_MEAS) ? ovf[IDX_BASE] : 1'b0;          // [R9] [R16] [R1]
    // gate is read after the synchroniser, so it acts two clocks late
    wire       gate_ok = s2_q.tin[i] == ctl_q[i][F_GATE];                // [R5]
    wire       a_ev   = tin_r[i] | tin_f[i];
    wire       quad_ev = a_ev | eud_e[i];                                // [R8]
    wire       quad_dn = a_ev ? (s2_q.tin[i] == s2_q.eud[i]) : (s2_q.tin[i] != s2_q.eud[i]);
    assign pin_ev[i] = (ctl_q[i][F_RISE] & tin_r[i]) | (ctl_q[i][F_FALL] & tin_f[i]);
    wire       cnt_ev = ctl_q[i][F_LATCLK] ? lat_ev : pin_ev[i];         // [R4] [R15]
    // one-hot view of the mode field keeps the event select a plain and-or
    wire       is_tim  = mode == MODE_TIMER;
    wire       is_gat  = mode == MODE_GATED;
    wire       is_cnt  = mode == MODE_COUNTER;
    wire       is_inc  = mode == MODE_INCR;
    wire       mode_ev = (is_tim & pre_ev) |
                         (is_gat & pre_ev & gate_ok) |
                         (is_cnt & cnt_ev) |
                         (is_inc & quad_ev);                             // [R2]
    // capture/reload role freezes the aux timer
    assign tick[i] = ctl_q[i][F_RUN] & (role == ROLE_NONE) & mode_ev;    // [R10]
    assign down[i] = (mode == MODE_INCR) ? quad_dn :
                     ctl_q[i][F_EXTDIR] ? s2_q.eud[i] : ctl_q[i][F_DOWN]; // [R7]
    // wrap is taken at the count extreme of the current direction
    assign ovf[i]  = tick[i] & (down[i] ? (cnt_q[i] == '0) : (cnt_q[i] == '1));
    assign step[i] = down[i] ? cnt_q[i] - TW'(1) : cnt_q[i] + TW'(1);
  end

  // module one interplay
  wire lat_rise = ovf[IDX_CORE] & ~core_lat_q;
  wire lat_fall = ovf[IDX_CORE] & core_lat_q;
  logic [NTIM-1:0] rld, cap;
  for (genvar j = 0; j < NTIM; j += 2) begin : g_aux
    if (j == IDX_A || j == IDX_B) begin : g_is_aux
      wire [1:0] role = ctl_q[j][F_ROLE+:2];
      wire       by_pin  = pin_ev[j];
      wire       by_rise = ctl_q[j][F_LRISE] & lat_rise;
      wire       by_fall = ctl_q[j][F_LFALL] & lat_fall;
      assign rld[j] = (role == ROLE_RELOAD) & (by_pin | by_rise | by_fall); // [R12] [R13]
      assign cap[j] = (role == ROLE_CAPTURE) & pin_ev[j];                // [R11]
    end else begin : g_not_aux
      assign rld[j] = 1'b0;
      assign cap[j] = 1'b0;
    end
  end
  assign rld[1] = 1'b0;
  assign rld[3] = 1'b0;
  assign cap[1] = 1'b0;
  assign cap[3] = 1'b0;

  // module two capture trigger
  wire capture_input_pin_edge = (cfg_q[C_RISE] & cap_r) | (cfg_q[C_FALL] & cap_f);
  wire cap_by_pin = cfg_q[C_PIN] & capture_input_pin_edge;                           // [R18]
  wire cap_by_tin = cfg_q[C_CIN] & (tin_r[IDX_CORE] | tin_f[IDX_CORE]);  // [R19]
  wire cap_by_eud = cfg_q[C_CDIR] & eud_e[IDX_CORE];                     // [R19]
  wire cap_ev     = cap_by_pin | cap_by_tin | cap_by_eud;
  // the reload replaces the wrapped value, so the base period is software's
  wire base_rld = ovf[IDX_BASE] & cfg_q[C_RLD];                          // [R17]

  // reload priority: aux_timer_a before aux_timer_b, both before counting
  wire [TW-1:0] run_a    = tick[IDX_A] ? step[IDX_A] : cnt_q[IDX_A];
  wire [TW-1:0] run_b    = tick[IDX_B] ? step[IDX_B] : cnt_q[IDX_B];
  wire [TW-1:0] run_core = tick[IDX_CORE] ? step[IDX_CORE] : cnt_q[IDX_CORE];
  wire [TW-1:0] rld_core = rld[IDX_A] ? cnt_q[IDX_A] : cnt_q[IDX_B];
  wire          core_rld = rld[IDX_A] | rld[IDX_B];
  wire [TW-1:0] run_meas = tick[IDX_MEAS] ? step[IDX_MEAS] : cnt_q[IDX_MEAS];
  wire          meas_clr = cap_ev & cfg_q[C_CLR];
  wire [TW-1:0] run_base = tick[IDX_BASE] ? step[IDX_BASE] : cnt_q[IDX_BASE];

  // an aux timer in capture role is frozen, so only the capture moves it
  assign cnt_d[IDX_A]    = cap[IDX_A] ? cnt_q[IDX_CORE] : run_a;         // [R11]
  assign cnt_d[IDX_B]    = cap[IDX_B] ? cnt_q[IDX_CORE] : run_b;         // [R11]
  // reload lands on the wrap edge, keeping every pwm period exact
  assign cnt_d[IDX_CORE] = core_rld ? rld_core : run_core;               // [R12]
  assign cnt_d[IDX_MEAS] = meas_clr ? '0 : run_meas;                     // [R18]
  assign cnt_d[IDX_BASE] = base_rld ? capture_reload_reg_q : run_base;               // [R17]

  function automatic logic word_is(input logic [3:0] at, input logic [3:0] want);
    return at == want;
  endfunction

  // apb decode; a refused word still finishes in one cycle
  wire        acc   = psel & penable;
  wire        wr    = acc & pwrite;
  wire [3:0]  idx   = paddr[5:2];
  wire        hit   = (paddr[1:0] == 2'h0) && (paddr <= OFF_LAST);
  wire [3:0]  i_cnt = 4'(OFF_CNT0 >> 2);
  wire [3:0]  i_cap = 4'(OFF_CAPTURE_RELOAD_REG >> 2);
  wire [3:0]  i_cfg = 4'(OFF_CAPCFG >> 2);
  wire [3:0]  i_flg = 4'(OFF_FLAGS >> 2);
  wire        wr_cap = wr & hit & word_is(idx, i_cap);
  wire        wr_cfg = wr & hit & word_is(idx, i_cfg);
  wire        wr_flg = wr & hit & word_is(idx, i_flg);

  // hardware capture wins over a software write in the same cycle
  wire [TW-1:0]    cap_src   = cnt_q[IDX_MEAS];
  wire [TW-1:0]    sw_cap    = pwdata[TW-1:0];
  assign capture_reload_reg_d = cap_ev ? cap_src : wr_cap ? sw_cap : capture_reload_reg_q;       // [R18]
  // set wins over write-one-to-clear, so a wrap in the clearing cycle is kept
  wire [NFLAG-1:0] flag_set  = {cap_ev, ovf};                            // [R20]
  wire [NFLAG-1:0] flag_clr  = wr_flg ? pwdata[NFLAG-1:0] : '0;
  wire [NFLAG-1:0] flag_keep = flag_q & ~flag_clr;
  assign flag_d = flag_keep | flag_set;

  // word select per region; upper bits of narrower fields read zero
  wire        in_ctl  = idx < i_cnt;
  wire        in_cnt  = (idx >= i_cnt) && (idx < i_cap);
  wire [2:0]  ctl_sel = idx[2:0];
  wire [3:0]  cnt_off = idx - i_cnt;
  wire [2:0]  cnt_sel = cnt_off[2:0];
  wire [31:0] rd_ctl  = 32'(ctl_q[ctl_sel]);
  wire [31:0] rd_cnt  = 32'(cnt_q[cnt_sel]);
  wire [31:0] rd_cap  = 32'(capture_reload_reg_q);
  wire [31:0] rd_cfg  = 32'(cfg_q);
  wire [31:0] rd_flg  = 32'(flag_q);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (in_ctl) begin
      rd_mux = rd_ctl;
    end else if (in_cnt) begin
      rd_mux = rd_cnt;
    end else begin
      case (idx)
        i_cap: begin
          rd_mux = rd_cap;
        end
        i_cfg: begin
          rd_mux = rd_cfg;
        end
        i_flg: begin
          rd_mux = rd_flg;
        end
        default: begin
          rd_mux = 32'h0000_0000;
        end
      endcase
    end
  end

  // read data captured in the setup phase, so prdata is a flop and pready can stay high
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= hit ? rd_mux : 32'h0000_0000;
    end
  end

  // one free-running prescaler for all timers: a new prescale acts without restart
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + PW'(1);
    end
  end

  for (genvar k = 0; k < NTIM; k++) begin : g_regs
    wire wr_ctl = wr & hit & (idx == 4'(k));
    wire wr_cnt = wr & hit & (idx == 4'(k) + i_cnt);
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        ctl_q[k] <= CTL_RST;
      end else if (wr_ctl) begin
        ctl_q[k] <= pwdata[CTL_W-1:0];
      end
    end
    // a software count write wins over whatever the timer does that cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        cnt_q[k] <= '0;
      end else begin
        cnt_q[k] <= wr_cnt ? pwdata[TW-1:0] : cnt_d[k];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      capture_reload_reg_q <= '0;
    end else begin
      capture_reload_reg_q <= capture_reload_reg_d;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= CFG_RST;
    end else if (wr_cfg) begin
      cfg_q <= pwdata[CFG_W-1:0];
    end
  end

  // latches flip on the wrap edge, the same edge that sets the request flag
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      core_lat_q <= 1'b0;
      base_lat_q <= 1'b0;
    end else begin
      core_lat_q <= core_lat_q ^ ovf[IDX_CORE];                          // [R9]
      base_lat_q <= base_lat_q ^ ovf[IDX_BASE];                          // [R16]
    end
  end

  // one clock late, but a clean flop output for the compare array clock
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      base_ovf_q <= 1'b0;
    end else begin
      base_ovf_q <= ovf[IDX_BASE];                                       // [R17]
    end
  end

  // no wait states: every register answers in the access cycle
  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;

  // a disabled toggle pin reads low while its latch keeps running
  assign outs.core_toggle_pin = core_lat_q & ctl_q[IDX_CORE][F_OE];
  assign outs.base_toggle_pin = base_lat_q & ctl_q[IDX_BASE][F_OE];
  assign outs.base_ovf        = base_ovf_q;
  assign outs.req             = flag_q;
endmodule // gtu_top

// ==== dv/gtu_top_sva.sv ====
/* port checker for gtu_top, bound into every instance.
   assumes one clock, clk_sys, and resetn async active low. */
`timescale 1ns/1ns
module gtu_top_sva (
  input wire logic              clk_sys,
  input wire logic              resetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire gtu_pkg::gtu_out_t outs
);
  import gtu_pkg::*;
  wire bad_a  = (paddr > OFF_LAST) || (paddr[1:0] != 2'h0);
  wire wr_acc = psel && penable && pwrite;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  property p_err; psel && penable && bad_a |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_rd_zero; psel && !penable && !pwrite && bad_a |=> prdata == 32'h0; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("refused read not zero");
  property p_ovf_out; $rose(outs.req[IDX_BASE]) |-> ##[0:1] outs.base_ovf; endproperty
  a_ovf_out: assert property (p_ovf_out) else $error("base overflow pulse missing");
  property p_ovf_cause; outs.base_ovf |-> outs.req[IDX_BASE] || $past(outs.req[IDX_BASE]); endproperty
  a_ovf_cause: assert property (p_ovf_cause) else $error("pulse without overflow");
  property p_ovf_gap; outs.base_ovf |=> !outs.base_ovf; endproperty
  a_ovf_gap: assert property (p_ovf_gap) else $error("overflows closer than two clocks");
  // a control write may move the pin through its enable, so those cycles are excused
  property p_core_tgl;
    $changed(outs.core_toggle_pin) && !$past(wr_acc) && !$past(wr_acc, 2) |-> outs.req[IDX_CORE];
  endproperty
  a_core_tgl: assert property (p_core_tgl) else $error("core pin moved without wrap");
  property p_base_tgl;
    $changed(outs.base_toggle_pin) && !$past(wr_acc) && !$past(wr_acc, 2) |-> outs.req[IDX_BASE];
  endproperty
  a_base_tgl: assert property (p_base_tgl) else $error("base pin moved without wrap");
  property p_flag_clr; |($past(outs.req) & ~outs.req) |-> $past(wr_acc && paddr == OFF_FLAGS); endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag dropped without clear");
  c_ovf: cover property (outs.base_ovf);
  c_err: cover property (pslverr);
  c_cap: cover property ($rose(outs.req[5]));
endmodule // gtu_top_sva
bind gtu_top gtu_top_sva chk (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .outs(outs));

// ==== dv/gtu_pin_model.sv ====
/* far-side pins: event pulses and a quadrature sensor on the core pins.
   assumes each level must last past the two-flop synchroniser. */
`timescale 1ns/1ns
module gtu_pin_model (
  input  wire logic          clk_sys,
  output gtu_pkg::gtu_pins_t pins
);
  import gtu_pkg::*;
  logic [1:0] phase;
  initial begin
    pins  = '0;
    phase = 2'h0;
  end
  // idx 0..4 is a timer input pin, 5 the capture input pin
  task automatic pulse(input int idx);
    @(posedge clk_sys);
    if (idx == 5) pins.capture_input_pin <= 1'b1;
    else pins.tin[idx] <= 1'b1;
    repeat (6) @(posedge clk_sys);
    if (idx == 5) pins.capture_input_pin <= 1'b0;
    else pins.tin[idx] <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
  // gray order 00,10,11,01 on A and B; forward counts up
  task automatic quad(input logic fwd);
    @(posedge clk_sys);
    phase = fwd ? phase + 2'h1 : phase - 2'h1;
    pins.tin[IDX_CORE] <= phase[1] ^ phase[0];
    pins.eud[IDX_CORE] <= phase[1];
    repeat (6) @(posedge clk_sys);
  endtask
endmodule // gtu_pin_model

// ==== dv/tb_top.sv ====
/* self-checking bench for gtu_top over apb with the pin model.
   assumes pready answers and pins settle within a few clocks. */
`timescale 1ns/1ns
module tb_top;
  import gtu_pkg::*;
  logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  gtu_pins_t   pins;
  gtu_out_t    outs;
  int          n_mismatch = 0, tests_run = 0, cyc = 0, hi, lo;
  localparam logic [31:0] RUN = 32'h4, DOWN = 32'h8, OE = 32'h1 << F_OE, RISE = 32'h1 << F_RISE;
  localparam logic [31:0] GATE = 32'h1 << F_GATE, LRISE = 32'h1 << F_LRISE, LFALL = 32'h1 << F_LFALL;
  localparam logic [31:0] CAPR = 32'(ROLE_CAPTURE) << F_ROLE, RLD = 32'(ROLE_RELOAD) << F_ROLE;
  gtu_top #(.TW(16), .PW(12)) uut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins(pins), .outs(outs));
  gtu_pin_model far (.clk_sys(clk_sys), .pins(pins));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  function automatic logic [11:0] ctl(input int i); return OFF_CTL0 + 12'(4 * i); endfunction
  function automatic logic [11:0] cnt(input int i); return OFF_CNT0 + 12'(4 * i); endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d); xfer(1'b1, a, d); endtask
  task automatic rdc(input string s, input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(s, e, rd);
  endtask
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 13; i++) rdc("reset word", 12'(4 * i), 32'h0);
    rdc("unmapped word", 12'h034, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    wr(cnt(IDX_A), 32'hFFFF_FFFF);
    rdc("count width", cnt(IDX_A), 32'h0000_FFFF);
    $display("registers done");
    wr(cnt(IDX_CORE), 32'h1);
    wr(ctl(IDX_CORE), RUN | DOWN | OE);
    repeat (30) @(posedge clk_sys);
    chk("core pin", 32'h1, {31'h0, outs.core_toggle_pin});
    rdc("underflow flag", OFF_FLAGS, 32'h2);
    wr(ctl(IDX_CORE), 32'h0);
    wr(OFF_FLAGS, 32'h3F);
    rdc("flags cleared", OFF_FLAGS, 32'h0);
    wr(cnt(IDX_A), 32'h0);
    wr(ctl(IDX_A), 32'(MODE_COUNTER) | RUN | RISE);
    repeat (5) far.pulse(IDX_A);
    rdc("counted events", cnt(IDX_A), 32'h5);
    wr(ctl(IDX_B), 32'(MODE_GATED) | RUN | GATE);
    repeat (40) @(posedge clk_sys);
    rdc("gate closed", cnt(IDX_B), 32'h0);
    wr(ctl(IDX_CORE), 32'(MODE_INCR) | RUN);
    wr(cnt(IDX_CORE), 32'h0);
    repeat (8) far.quad(1'b1);
    rdc("forward steps", cnt(IDX_CORE), 32'h8);
    repeat (3) far.quad(1'b0);
    rdc("backward steps", cnt(IDX_CORE), 32'h5);
    $display("module one modes done");
    wr(ctl(IDX_CORE), 32'h0);
    wr(cnt(IDX_CORE), 32'h1234);
    wr(ctl(IDX_B), CAPR | RUN | RISE);
    wr(cnt(IDX_B), 32'h0);
    repeat (20) @(posedge clk_sys);
    rdc("capture role stopped", cnt(IDX_B), 32'h0);
    far.pulse(IDX_B);
    rdc("captured core", cnt(IDX_B), 32'h1234);
    // latch falls first: low time from aux b, high time from aux a
    wr(cnt(IDX_CORE), 32'hFFFE);
    wr(cnt(IDX_A), 32'hFFF0);
    wr(cnt(IDX_B), 32'hFFF8);
    wr(ctl(IDX_A), RLD | LRISE);
    wr(ctl(IDX_B), RLD | LFALL);
    wr(ctl(IDX_CORE), RUN | OE);
    @(negedge clk_sys);
    while (outs.core_toggle_pin !== 1'b0) @(negedge clk_sys);
    while (outs.core_toggle_pin !== 1'b1) @(negedge clk_sys);
    for (hi = 0; outs.core_toggle_pin === 1'b1; hi++) @(negedge clk_sys);
    for (lo = 0; outs.core_toggle_pin === 1'b0; lo++) @(negedge clk_sys);
    chk("pwm high clocks", 32'h40, hi);
    chk("pwm low clocks", 32'h20, lo);
    wr(ctl(IDX_CORE), 32'h0);
    wr(OFF_FLAGS, 32'h3F);
    $display("capture and reload done");
    wr(cnt(IDX_MEAS), 32'h42);
    wr(OFF_CAPCFG, (32'h1 << C_RISE) | (32'h1 << C_PIN) | (32'h1 << C_CLR));
    far.pulse(5);
    rdc("capture of measure", OFF_CAPTURE_RELOAD_REG, 32'h42);
    rdc("measure cleared", cnt(IDX_MEAS), 32'h0);
    rdc("capture flag", OFF_FLAGS, 32'h20);
    wr(cnt(IDX_MEAS), 32'h77);
    wr(OFF_CAPCFG, (32'h1 << C_RISE) | (32'h1 << C_FALL) | (32'h1 << C_CIN));
    far.pulse(IDX_CORE);
    rdc("capture from core pin", OFF_CAPTURE_RELOAD_REG, 32'h77);
    wr(OFF_CAPTURE_RELOAD_REG, 32'hFFFC);
    wr(OFF_CAPCFG, 32'h1 << C_RLD);
    wr(cnt(IDX_BASE), 32'hFFF0);
    wr(ctl(IDX_BASE), RUN | OE);
    repeat (60) @(posedge clk_sys);
    hi = 0;
    lo = 0;
    repeat (80) begin
      @(negedge clk_sys);
      hi += int'(outs.base_toggle_pin === 1'b1);
      lo += int'(outs.base_ovf === 1'b1);
    end
    chk("base pin high clocks", 32'h28, hi);
    chk("base overflow pulses", 32'hA, lo);
    rdc("base flag", OFF_FLAGS, 32'h30);
    $display("module two done");
    tally_and_finish();
  end
endmodule // tb_top
